// ---- shared/npic_pkg.sv ----
package npic_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CC      = 8'h00;
  localparam logic [7:0] ADDR_ISPR0   = 8'h04;
  localparam logic [7:0] ADDR_ISPR3   = 8'h10;
  localparam logic [7:0] ADDR_ENABLE  = 8'h14;
  localparam logic [7:0] ADDR_PENDING = 8'h18;
  localparam logic [7:0] ADDR_SENSE   = 8'h1c;
  localparam logic [7:0] ADDR_MOTOR   = 8'h20;
  localparam logic [7:0] ADDR_CTRL    = 8'h24;

  localparam logic [7:0]  CC_RESET     = 8'hea;
  localparam logic [7:0]  ISPR_RESET   = 8'hff;
  localparam logic [3:0]  ISPR3_RO     = 4'hf;
  localparam logic [13:0] ENABLE_RESET = 14'h0000;
  localparam logic [5:0]  SENSE_RESET  = 6'h00;
  localparam logic [1:0]  MOTOR_RESET  = 2'h0;
  localparam logic        NESTED_RESET = 1'b1;

  localparam int CC_HI_BIT   = 5;
  localparam int CC_LO_BIT   = 3;
  localparam int MOT_EN_BIT  = 0;
  localparam int MOT_RISE_BIT = 1;
  localparam int CTRL_NEST_BIT = 0;
  localparam int CTRL_HALT_BIT = 1;
  localparam int CTRL_WAIT_BIT = 2;

  // ----------------------------------------------------------------
  // priority encodings, vectors
  // ----------------------------------------------------------------
  localparam logic [1:0] PRIO_L0 = 2'h2;
  localparam logic [1:0] PRIO_L3 = 2'h3;

  localparam int          NVEC      = 14;
  localparam int          NPIN      = 8;
  localparam logic [3:0]  IDX_ESTOP = 4'h0;
  localparam logic [3:0]  IDX_EXT0  = 4'h2;
  localparam logic [3:0]  IDX_TRAP  = 4'he;
  localparam logic [15:0] VEC_BASE  = 16'hfffa;
  localparam logic [15:0] VEC_TRAP  = 16'hfffc;
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_LOW   = 16'hffe0;
  localparam logic [13:0] WAKE_MASK   = 14'h111f;
  localparam logic [13:0] PERIPH_MASK = 14'h3fe2;

  // sense codes per external line
  localparam logic [1:0] SENSE_FALL     = 2'h0;
  localparam logic [1:0] SENSE_RISE     = 2'h1;
  localparam logic [1:0] SENSE_BOTH     = 2'h2;
  localparam logic [1:0] SENSE_FALL_LOW = 2'h3;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_RELEASE_MASK, CMD_SET_MAX_MASK, CMD_HALT,
    CMD_WAIT, CMD_IRQ_RETURN, CMD_POP_CC, CMD_SOFT_NMI
  } npic_cmd_e;

  typedef struct packed {
    logic      instr_done;
    npic_cmd_e cmd;
    logic [7:0] cc_pop;
    logic      push_done;
  } npic_core_req_s;

  typedef struct packed {
    logic       push_ctx;
    logic       vec_valid;
    logic [15:0] vector;
    logic       run;
    logic [7:0] cc;
  } npic_core_rsp_s;
endpackage

// ---- rtl/npic_top.sv ----
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps
module npic_top
  import npic_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire npic_core_req_s        core_req,
  output npic_core_rsp_s             core_rsp,
  input  wire logic [NPIN-1:0]       ext_pin,
  input  wire logic                  estop_pin,
  input  wire logic                  speed_err,
  input  wire logic [NVEC-1:0]       periph_flag,
  input  wire logic [NVEC-1:0]       periph_en
);
  typedef enum logic [1:0] {ST_BOOT, ST_RUN, ST_STACK} npic_state_e;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] lvl(input logic [1:0] enc);
    case (enc)
      2'h2:    lvl = 2'h0;
      2'h1:    lvl = 2'h1;
      2'h0:    lvl = 2'h2;
      default: lvl = 2'h3;
    endcase
  endfunction

  function automatic logic [7:0] ispr_merge(input logic [7:0] old_v, input logic [7:0] new_v);
    ispr_merge = new_v;
    for (int p = 0; p < 4; p++) begin
      if (new_v[2*p +: 2] == PRIO_L0) begin
        ispr_merge[2*p +: 2] = old_v[2*p +: 2];
      end
    end
  endfunction

  logic [7:0]      cc_reg;
  logic [7:0]      ispr_reg [4];
  logic [13:0]     enable_reg;
  logic [13:0]     pend_reg;
  logic [5:0]      sense_reg;
  logic [1:0]      motor_reg;
  logic            nested_reg;
  logic            halted_reg;
  logic            waiting_reg;
  logic            trap_pend_reg;
  logic [3:0]      depth_reg;
  logic [3:0]      gidx_reg;
  npic_state_e     state_reg;
  npic_core_rsp_s  rsp_reg;
  logic [31:0]     hrdata_reg;
  logic            hreadyout_reg;
  logic            hresp_reg;

  logic [1:0] cur_pair;
  assign cur_pair = {cc_reg[CC_HI_BIT], cc_reg[CC_LO_BIT]};

  function automatic logic [1:0] pair_of(input logic [3:0] idx, input logic [7:0] r0,
                                         input logic [7:0] r1, input logic [7:0] r2,
                                         input logic [7:0] r3);
    logic [7:0] r;
    case (idx[3:2])
      2'h0:    r = r0;
      2'h1:    r = r1;
      2'h2:    r = r2;
      default: r = r3;
    endcase
    pair_of = r[{idx[1:0], 1'b0} +: 2];
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [NPIN:0] pin_s1, pin_s2, pin_s3;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= '1;
      pin_s2 <= '1;
      pin_s3 <= '1;
    end else begin
      pin_s1 <= {estop_pin, ext_pin};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  logic [NPIN:0] fall, rise;
  assign fall = pin_s3 & ~pin_s2;
  assign rise = ~pin_s3 & pin_s2;

  // three external lines: pins 2:0, 5:3, 7:6
  logic [2:0] grp_fall, grp_rise, grp_low;
  assign grp_fall = {|fall[7:6], |fall[5:3], |fall[2:0]};
  assign grp_rise = {|rise[7:6], |rise[5:3], |rise[2:0]};
  assign grp_low  = {~&pin_s2[7:6], ~&pin_s2[5:3], ~&pin_s2[2:0]};

  logic [2:0] ext_set;
  logic [2:0] ext_edge_mode;
  generate
    for (genvar g = 0; g < 3; g++) begin : g_ext
      logic [1:0] sm;
      assign sm = sense_reg[2*g +: 2];
      assign ext_set[g] = (sm == SENSE_FALL     && grp_fall[g]) ||
                          (sm == SENSE_RISE     && grp_rise[g]) ||
                          (sm == SENSE_BOTH     && (grp_fall[g] || grp_rise[g])) ||
                          (sm == SENSE_FALL_LOW && (grp_fall[g] || grp_low[g]));
      assign ext_edge_mode[g] = (sm != SENSE_FALL_LOW);
    end
  endgenerate

  logic estop_edge, estop_hold;
  assign estop_edge = motor_reg[MOT_RISE_BIT] ? rise[NPIN] : fall[NPIN];
  assign estop_hold = motor_reg[MOT_EN_BIT] && !pin_s2[NPIN];

  logic [13:0] req_set;
  always_comb begin
    req_set = periph_flag & periph_en & PERIPH_MASK;
    req_set[IDX_ESTOP] = estop_edge || speed_err || estop_hold;
    req_set[4:2] = ext_set;
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  logic       found;
  logic [3:0] best_idx;
  logic [1:0] best_lvl;
  always_comb begin
    found    = 1'b0;
    best_idx = '0;
    best_lvl = '0;
    // walk low to high hardware priority so a tie keeps the lower index
    for (int i = NVEC - 1; i >= 1; i--) begin
      logic [1:0] l;
      l = lvl(pair_of(4'(i), ispr_reg[0], ispr_reg[1], ispr_reg[2], ispr_reg[3]));
      if (pend_reg[i] && enable_reg[i] && l > lvl(cur_pair) &&
          (!halted_reg || WAKE_MASK[i]) &&
          (nested_reg || depth_reg == '0) &&
          (!found || l >= best_lvl)) begin
        found    = 1'b1;
        best_idx = 4'(i);
        best_lvl = l;
      end
    end
    // non-maskable kinds ignore the current level
    if (pend_reg[IDX_ESTOP]) begin
      found    = 1'b1;
      best_idx = IDX_ESTOP;
    end
    if (trap_pend_reg) begin
      found    = 1'b1;
      best_idx = IDX_TRAP;
    end
  end

  logic grant;
  assign grant = (state_reg == ST_RUN) && found &&
                 (core_req.instr_done || halted_reg || waiting_reg);

  logic entry;
  assign entry = (state_reg == ST_STACK) && core_req.push_done;

  logic [1:0] sel_pair;
  assign sel_pair = pair_of(gidx_reg, ispr_reg[0], ispr_reg[1], ispr_reg[2], ispr_reg[3]);

  logic nmi_entry;
  assign nmi_entry = (gidx_reg == IDX_TRAP) || (gidx_reg == IDX_ESTOP);

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic       ap_wr_reg;
  logic [7:0] ap_addr_reg;
  logic       ap_take;
  assign ap_take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_reg     <= 1'b0;
      ap_addr_reg   <= '0;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end else begin
      ap_wr_reg     <= ap_take && hwrite;
      ap_addr_reg   <= haddr[7:0];
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end
  end

  logic wr_cc, wr_en, wr_pend, wr_sense, wr_motor, wr_ctrl;
  assign wr_cc    = ap_wr_reg && ap_addr_reg == ADDR_CC;
  assign wr_en    = ap_wr_reg && ap_addr_reg == ADDR_ENABLE;
  assign wr_pend  = ap_wr_reg && ap_addr_reg == ADDR_PENDING;
  assign wr_sense = ap_wr_reg && ap_addr_reg == ADDR_SENSE;
  assign wr_motor = ap_wr_reg && ap_addr_reg == ADDR_MOTOR;
  assign wr_ctrl  = ap_wr_reg && ap_addr_reg == ADDR_CTRL;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (haddr[7:0])
      ADDR_CC:      rd_mux = {24'h0, cc_reg};
      ADDR_ENABLE:  rd_mux = {18'h0, enable_reg};
      ADDR_PENDING: rd_mux = {18'h0, pend_reg};
      ADDR_SENSE:   rd_mux = {26'h0, sense_reg};
      ADDR_MOTOR:   rd_mux = {30'h0, motor_reg};
      ADDR_CTRL:    rd_mux = {24'h0, depth_reg, 1'b0, waiting_reg, halted_reg, nested_reg};
      default: begin
        if (haddr[7:0] >= ADDR_ISPR0 && haddr[7:0] <= ADDR_ISPR3 && haddr[1:0] == 2'h0) begin
          rd_mux = {24'h0, ispr_reg[2'(haddr[7:2] - 6'h1)]};
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= '0;
    end else if (ap_take && !hwrite) begin
      hrdata_reg <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  generate
    for (genvar r = 0; r < 4; r++) begin : g_ispr
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ispr_reg[r] <= ISPR_RESET;
        end else if (ap_wr_reg && ap_addr_reg == ADDR_ISPR0 + 8'(4 * r)) begin
          ispr_reg[r] <= ispr_merge(ispr_reg[r], hwdata[7:0]);
          if (r == 3) begin
            ispr_reg[r][7:4] <= ISPR3_RO;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_reg <= ENABLE_RESET;
      sense_reg  <= SENSE_RESET;
      motor_reg  <= MOTOR_RESET;
      nested_reg <= NESTED_RESET;
    end else begin
      if (wr_en)    enable_reg <= hwdata[13:0];
      if (wr_sense) sense_reg  <= hwdata[5:0];
      if (wr_motor) motor_reg  <= hwdata[1:0];
      if (wr_ctrl)  nested_reg <= hwdata[CTRL_NEST_BIT];
    end
  end

  // ----------------------------------------------------------------
  // pending latches; a new request beats any clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg <= '0;
    end else begin
      for (int i = 0; i < NVEC; i++) begin
        if (req_set[i]) begin
          pend_reg[i] <= 1'b1;
        end else if (wr_pend && hwdata[i]) begin
          pend_reg[i] <= 1'b0;
        end else if (entry && gidx_reg == 4'(i) && !PERIPH_MASK[i] &&
                     (i == 0 || ext_edge_mode[(i - 2) % 3])) begin
          pend_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trap_pend_reg <= 1'b0;
    end else if (state_reg == ST_RUN && core_req.cmd == CMD_SOFT_NMI) begin
      trap_pend_reg <= 1'b1;
    end else if (entry && gidx_reg == IDX_TRAP) begin
      trap_pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // entry sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_BOOT;
      gidx_reg  <= '0;
      rsp_reg   <= '0;
    end else begin
      rsp_reg.vec_valid <= 1'b0;
      case (state_reg)
        ST_BOOT: begin
          rsp_reg.vec_valid <= 1'b1;
          rsp_reg.vector    <= VEC_RESET;
          state_reg         <= ST_RUN;
        end
        ST_RUN: begin
          if (grant) begin
            gidx_reg         <= best_idx;
            rsp_reg.push_ctx <= 1'b1;
            state_reg        <= ST_STACK;
          end
        end
        ST_STACK: begin
          if (core_req.push_done) begin
            rsp_reg.push_ctx  <= 1'b0;
            rsp_reg.vec_valid <= 1'b1;
            rsp_reg.vector    <= (gidx_reg == IDX_TRAP) ? VEC_TRAP :
                                 VEC_BASE - {11'h0, gidx_reg, 1'b0};
            state_reg         <= ST_RUN;
          end
        end
        default: state_reg <= ST_RUN;
      endcase
      rsp_reg.run <= !halted_reg && !waiting_reg;
    end
  end

  // ----------------------------------------------------------------
  // condition-code priority bits, low-power state, nesting depth
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cc_reg <= CC_RESET;
    end else if (entry) begin
      if (nmi_entry) begin
        {cc_reg[CC_HI_BIT], cc_reg[CC_LO_BIT]} <= PRIO_L3;
      end else begin
        {cc_reg[CC_HI_BIT], cc_reg[CC_LO_BIT]} <= sel_pair;
      end
    end else if (state_reg == ST_RUN) begin
      case (core_req.cmd)
        CMD_RELEASE_MASK, CMD_HALT, CMD_WAIT:
          {cc_reg[CC_HI_BIT], cc_reg[CC_LO_BIT]} <= PRIO_L0;
        CMD_SET_MAX_MASK:
          {cc_reg[CC_HI_BIT], cc_reg[CC_LO_BIT]} <= PRIO_L3;
        CMD_IRQ_RETURN, CMD_POP_CC:
          cc_reg <= core_req.cc_pop;
        default: begin
          if (wr_cc) cc_reg <= hwdata[7:0];
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      halted_reg  <= 1'b0;
      waiting_reg <= 1'b0;
      depth_reg   <= '0;
    end else begin
      if (grant) begin
        halted_reg  <= 1'b0;
        waiting_reg <= 1'b0;
      end else if (state_reg == ST_RUN && core_req.cmd == CMD_HALT) begin
        halted_reg <= 1'b1;
      end else if (state_reg == ST_RUN && core_req.cmd == CMD_WAIT) begin
        waiting_reg <= 1'b1;
      end
      if (entry && depth_reg != 4'hf) begin
        depth_reg <= depth_reg + 4'h1;
      end else if (state_reg == ST_RUN && core_req.cmd == CMD_IRQ_RETURN &&
                   depth_reg != '0) begin
        depth_reg <= depth_reg - 4'h1;
      end
    end
  end

  always_comb begin
    core_rsp    = rsp_reg;
    core_rsp.cc = cc_reg;
  end
  assign hrdata    = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic any_l0;
  always_comb begin
    any_l0 = 1'b0;
    for (int r = 0; r < 4; r++) begin
      for (int p = 0; p < 4; p++) begin
        if (ispr_reg[r][2*p +: 2] == PRIO_L0) any_l0 = 1'b1;
      end
    end
  end

  sequence s_grant;
    state_reg == ST_RUN && grant;
  endsequence
  sequence s_entry_mask;
    entry && !nmi_entry;
  endsequence

  AST_BOOT_LEVEL3: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_BOOT |-> cur_pair == PRIO_L3)
    else $error("cc not at level 3 after reset");
  AST_GRANT_BOUNDARY: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(rsp_reg.push_ctx) |-> $past(core_req.instr_done || halted_reg || waiting_reg))
    else $error("grant taken mid instruction");
  AST_PUSH_THEN_VECTOR: assert property (@(posedge hclk) disable iff (!hresetn)
    s_grant ##1 rsp_reg.push_ctx[*1] |-> !rsp_reg.vec_valid)
    else $error("vector issued before context push");
  AST_ENTRY_PRIO: assert property (@(posedge hclk) disable iff (!hresetn)
    s_entry_mask |=> cur_pair == $past(sel_pair))
    else $error("entry did not load software priority");
  AST_NMI_LEVEL3: assert property (@(posedge hclk) disable iff (!hresetn)
    entry && nmi_entry |=> cur_pair == PRIO_L3)
    else $error("non-maskable entry left level below 3");
  AST_VECTOR_RANGE: assert property (@(posedge hclk) disable iff (!hresetn)
    rsp_reg.vec_valid |-> rsp_reg.vector >= VEC_LOW && !rsp_reg.vector[0])
    else $error("vector outside table");
  AST_NO_LEVEL0: assert property (@(posedge hclk) disable iff (!hresetn)
    !any_l0)
    else $error("priority pair holds level 0");
  AST_RETURN_RESTORES: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ST_RUN && !entry && core_req.cmd == CMD_IRQ_RETURN
    |=> cc_reg == $past(core_req.cc_pop))
    else $error("irq_return did not restore cc");
  AST_HALT_WAKE_CAP: assert property (@(posedge hclk) disable iff (!hresetn)
    s_grant and halted_reg |=> gidx_reg == IDX_TRAP || WAKE_MASK[gidx_reg])
    else $error("halt exit served non wake source");
  AST_TRAP_SERVED: assert property (@(posedge hclk) disable iff (!hresetn)
    trap_pend_reg && state_reg == ST_RUN && core_req.instr_done |=> gidx_reg == IDX_TRAP)
    else $error("pending soft_nmi not granted");
endmodule

// ---- verif/npic_core_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------
// core side: boundaries, stacking, vector load
// ----------------------------------------------------------------
module npic_core_model
  import npic_pkg::*;
#(
  parameter int STALL = 2
)(
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire npic_core_rsp_s rsp,
  input  wire npic_cmd_e      cmd,
  input  wire logic [7:0]     cc_pop,
  output npic_core_req_s      req,
  output logic [15:0]         pc_reg
);
  logic [3:0] stall_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req       <= '0;
      stall_reg <= 4'h0;
      pc_reg    <= 16'h0000;
    end else begin
      // boundary every other cycle, none while stacking
      req.instr_done <= ~req.instr_done & ~rsp.push_ctx;
      req.cmd        <= rsp.push_ctx ? CMD_NONE : cmd;
      req.cc_pop     <= cc_pop;
      // pc, x, a and cc take STALL+1 cycles, so a slow core is exercised
      req.push_done  <= rsp.push_ctx && !req.push_done && stall_reg == 4'(STALL);
      stall_reg      <= (rsp.push_ctx && !req.push_done) ? stall_reg + 4'h1 : 4'h0;
      if (rsp.vec_valid) begin
        pc_reg <= rsp.vector;
      end
    end
  end
endmodule

// ---- verif/test_nested_priority_interrupt_controller.sv ----
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module test_nested_priority_interrupt_controller
  import npic_pkg::*;
();
  logic            hclk, hresetn, hsel, hwrite, hready, hresp, estop_pin, speed_err;
  logic [1:0]      htrans;
  logic [2:0]      hsize;
  logic [31:0]     haddr, hwdata, hrdata;
  logic [NPIN-1:0] ext_pin;
  logic [NVEC-1:0] periph_flag, periph_en;
  logic [15:0]     pc_reg;
  logic [7:0]      cc_pop;
  npic_cmd_e       cmd;
  npic_core_req_s  core_req;
  npic_core_rsp_s  core_rsp;
  int              mismatches, comparisons;
  localparam logic [7:0] ADDR_ISPR1 = ADDR_ISPR0 + 8'h04;

  npic_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .core_req(core_req),
    .core_rsp(core_rsp), .ext_pin(ext_pin), .estop_pin(estop_pin),
    .speed_err(speed_err), .periph_flag(periph_flag), .periph_en(periph_en));

  npic_core_model #(.STALL(3)) core (.hclk(hclk), .hresetn(hresetn), .rsp(core_rsp),
    .cmd(cmd), .cc_pop(cc_pop), .req(core_req), .pc_reg(pc_reg));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // bus and core helpers
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    xfer(1'b1, a, d, rd);
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] rd;
    xfer(1'b0, a, 32'h00000000, rd);
    `CHK(n, e, rd)
  endtask

  task automatic issue(input npic_cmd_e c, input logic [7:0] p);
    @(posedge hclk);
    cmd    <= c;
    cc_pop <= p;
    @(posedge hclk);
    cmd    <= CMD_NONE;
  endtask

  // the pulse lasts one cycle, so it is sampled at the edge that closes it
  // one edge first, so a pulse seen by the previous call is not taken twice
  task automatic entry(input string n, input logic [15:0] v, input logic [1:0] lvl);
    @(posedge hclk);
    for (int i = 0; i < 60 && core_rsp.vec_valid !== 1'b1; i++) @(posedge hclk);
    `CHK(n, 1'b1, core_rsp.vec_valid)
    `CHK(n, v, core_rsp.vector)
    `CHK(n, lvl, {core_rsp.cc[CC_HI_BIT], core_rsp.cc[CC_LO_BIT]})
  endtask

  task automatic ret(input logic [7:0] p, input logic [1:0] lvl);
    issue(CMD_IRQ_RETURN, p);
    repeat (4) @(posedge hclk);
    `CHK("ret_level", lvl, {core_rsp.cc[CC_HI_BIT], core_rsp.cc[CC_LO_BIT]})
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    repeat (4) @(posedge hclk);
    `CHK("boot", VEC_RESET, pc_reg)
    `CHK("cc_reset", 8'hea, core_rsp.cc & 8'hef)
    for (int i = 0; i < 4; i++) rd_chk("ispr", ADDR_ISPR0 + 8'(4 * i), 32'hff);
    rd_chk("unmapped", 8'h40, 32'h00000000);
    $display("test reset done");
  endtask

  task automatic t_ispr();
    wr(ADDR_ISPR0, 32'hcf);
    wr(ADDR_ISPR0, 32'h64);
    rd_chk("ispr0", ADDR_ISPR0, 32'h44);
    wr(ADDR_ISPR3, 32'h00);
    rd_chk("ispr3", ADDR_ISPR3, 32'hf0);
    $display("test ispr done");
  endtask

  task automatic t_nest();
    wr(ADDR_ISPR1, 32'hf7);
    wr(ADDR_ENABLE, 32'h0020);
    periph_en   <= 14'h0020;
    periph_flag <= 14'h0020;
    repeat (10) @(posedge hclk);
    `CHK("masked", VEC_RESET, pc_reg)
    issue(CMD_RELEASE_MASK, 8'h00);
    entry("periph", 16'hfff0, 2'h1);
    periph_flag <= '0;
    speed_err   <= 1'b1;
    @(posedge hclk);
    speed_err   <= 1'b0;
    entry("estop", VEC_BASE, 2'h3);
    ret(8'hca, 2'h1);
    `CHK("no_reentry", VEC_BASE, pc_reg)
    ret(8'hea, 2'h3);
    $display("test nest done");
  endtask

  task automatic t_arb();
    wr(ADDR_ISPR1, 32'h17);
    wr(ADDR_ENABLE, 32'h00c0);
    periph_en   <= 14'h00c0;
    periph_flag <= 14'h00c0;
    issue(CMD_RELEASE_MASK, 8'h00);
    entry("arb", 16'hffec, 2'h0);
    periph_flag <= '0;
    // software clear drops every latched request, so release takes nothing
    wr(ADDR_PENDING, 32'h3fff);
    rd_chk("pend_clr", ADDR_PENDING, 32'h0);
    issue(CMD_RELEASE_MASK, 8'h00);
    repeat (12) @(posedge hclk);
    `CHK("lost", 16'hffec, pc_reg)
    ret(8'hea, 2'h3);
    $display("test arb done");
  endtask

  task automatic t_trap();
    issue(CMD_SOFT_NMI, 8'h00);
    entry("trap", VEC_TRAP, 2'h3);
    ret(8'hea, 2'h3);
    $display("test trap done");
  endtask

  task automatic t_halt();
    wr(ADDR_ISPR1, 32'h3f);
    wr(ADDR_ENABLE, 32'h0024);
    periph_en   <= 14'h0020;
    periph_flag <= 14'h0020;
    issue(CMD_HALT, 8'h00);
    repeat (4) @(posedge hclk);
    `CHK("halt_lvl", 2'h2, {core_rsp.cc[CC_HI_BIT], core_rsp.cc[CC_LO_BIT]})
    `CHK("halt_run", 1'b0, core_rsp.run)
    // vector 5 outranks line 0 but cannot end halt, so it follows the first entry
    ext_pin <= 8'hfd;
    entry("wake", 16'hfff6, 2'h0);
    entry("after_halt", 16'hfff0, 2'h3);
    periph_flag <= '0;
    wr(ADDR_PENDING, 32'h0020);
    rd_chk("ext_clr", ADDR_PENDING, 32'h0);
    ret(8'hc2, 2'h0);
    ret(8'hea, 2'h3);
    ext_pin <= '1;
    $display("test halt done");
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, speed_err} = 3'h0;
    estop_pin = 1'b1;
    htrans = 2'h0;
    hsize = 3'h2;
    {haddr, hwdata} = '0;
    // pins idle high, as the synchroniser resets, so no false edge follows reset
    ext_pin = '1;
    {periph_flag, periph_en} = '0;
    cmd = CMD_NONE;
    cc_pop = 8'h00;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_ispr();
    t_nest();
    t_arb();
    t_trap();
    t_halt();
    finish_test();
  end

  // a hang anywhere ends the run as a failure
  initial begin
    repeat (5000) @(posedge hclk);
    mismatches++;
    finish_test();
  end
endmodule
